//--- rtl/scsw_clock_ctrl.sv
// System clock selection, PLL timing and start-up sequencing.
// Assumes oscillator pins arrive asynchronously and are far slower than i_clk;
// the system clock is delivered as a one-cycle enable, not a real clock.
//
// How it works
// - PLL mode yields four system ticks per main oscillator period.
// - PLL only in high-speed PLL mode; otherwise ticks follow the input pin.
// - A PLL lock timer must expire before execution starts.
// - Clock switching works only when the switch enable config bit is 0.
// - Select bit 0 runs from main oscillator, 1 from secondary oscillator.
// - Every reset clears the select bit, back to main oscillator.
// - Select writes ignored and bit held 0 unless secondary enabled and switching allowed.
// - Upper 31 bits of oscillator control read as zero.
// - Any source change waits eight rising edges of the new source.
// - Switch to secondary freezes at next first quarter, resumes after eight edges.
// - Back to a crystal main oscillator also waits the start-up time; an external or watchdog reset while running skips it.
// - Back to PLL mode waits start-up time plus 2 ms lock time.
// - Back to RC or external clock: no start-up wait, just eight edges.
// - SLEEP stops clocks and oscillator, holding the core at first quarter.
// - SLEEP ends on external reset, watchdog reset or interrupt.
// - In SLEEP the output pin is low, GPIO or inverter-disabled, by mode.
// - Power-up timer holds reset 72 ms, only after power-on or brown-out.
// - Start-up timer holds reset until the crystal is stable.
// - PLL power-on: power-up timer, start-up timer, then 2 ms lock.
// - Start-up timer counts 1024 input pin edges after power-up timer.
// - Start-up timer runs only in crystal modes, after power-on, brown-out, wake or a switch back to main.
// - RC and external clock modes without GPIO drive input frequency over four out.
`timescale 1ns/1ps
module scsw_clock_ctrl #(
	parameter int unsigned P_POWERUP_DELAY_TIMER_CYCLES = scsw_pkg::POWERUP_DELAY_TIMER_CYCLES,
	parameter int unsigned P_PLL_LOCK_CYCLES = scsw_pkg::PLL_LOCK_CYCLES
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	// APB slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// Configuration and core-side controls
	input wire logic [2:0] i_osc_mode_cfg,
	input wire logic i_clock_switch_enable_cfg,
	input wire logic i_powerup_delay_enable,
	input wire logic i_secondary_osc_enable,
	input wire logic i_brownout_reset,
	input wire logic i_ext_reset,
	input wire logic i_wdt_reset,
	input wire logic i_wake_irq,
	input wire logic i_sleep_req,
	// Asynchronous oscillator side
	input wire logic i_osc_input_pin,
	input wire logic i_secondary_osc_pin,
	input wire logic i_secondary_osc_running,
	// Outputs
	output logic o_sys_clk_tick,
	output logic [1:0] o_q_phase,
	output logic o_hold_in_reset,
	output logic o_core_frozen,
	output logic o_pll_enable,
	output logic o_main_osc_enable,
	output logic o_osc_feedback_enable,
	output logic o_osc_output_pin_o,
	output logic o_osc_output_pin_oe,
	output logic o_port_a_bit6_gpio,
	output logic o_sys_clock_is_secondary
);

	localparam int unsigned TW = scsw_pkg::TMR_W;
	localparam logic [TW-1:0] POWERUP_DELAY_TIMER_LAST = TW'(P_POWERUP_DELAY_TIMER_CYCLES - 1);
	localparam logic [TW-1:0] PLL_LAST = TW'(P_PLL_LOCK_CYCLES - 1);
	localparam logic [TW-1:0] OST_LAST = TW'(scsw_pkg::OST_EDGES - 1);
	localparam logic [TW-1:0] SYNC_LAST = TW'(scsw_pkg::SYNC_EDGES - 1);
	localparam logic [TW-1:0] TMR_ZERO = '0;
	localparam logic [1:0] Q_FIRST = 2'h0;
	localparam logic [1:0] Q_LAST = 2'h3;

	// ----------------------------------------------------------------
	// Mode decoding
	// ----------------------------------------------------------------
	// Crystal modes need the start-up timer and keep the feedback inverter
	function automatic logic is_crystal(input logic [2:0] m);
		is_crystal = (m == scsw_pkg::MODE_LOW_POWER_CRYSTAL) ||
			(m == scsw_pkg::MODE_CRYSTAL_RESONATOR) ||
			(m == scsw_pkg::MODE_HIGH_SPEED_CRYSTAL) ||
			(m == scsw_pkg::MODE_HIGH_SPEED_PLL);
	endfunction : is_crystal

	// Modes whose output pin is handed to the port as bit 6
	function automatic logic is_gpio_mode(input logic [2:0] m);
		is_gpio_mode = (m == scsw_pkg::MODE_RESISTOR_CAP_OSC_GPIO) ||
			(m == scsw_pkg::MODE_EXTERNAL_CLOCK_IN_GPIO);
	endfunction : is_gpio_mode

	wire logic pll_mode = (i_osc_mode_cfg == scsw_pkg::MODE_HIGH_SPEED_PLL);
	wire logic crystal_mode = is_crystal(i_osc_mode_cfg);
	wire logic gpio_mode = is_gpio_mode(i_osc_mode_cfg);
	wire logic div4_mode = !crystal_mode && !gpio_mode;

	// ----------------------------------------------------------------
	// Synchronisers for the asynchronous oscillator inputs
	// ----------------------------------------------------------------
	// A change counts only once stages two and three agree, which also
	// rejects a single sampled glitch on a slow crystal edge
	logic [2:0] async_in;
	logic [2:0] filt;
	logic [2:0] rise;
	assign async_in = {i_secondary_osc_running, i_secondary_osc_pin, i_osc_input_pin};

	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_sync
			logic s1_reg;
			logic s2_reg;
			logic s3_reg;
			logic filt_reg;
			wire logic agree = (s2_reg == s3_reg);
			always_ff @(posedge i_clk) begin
				if (!i_rst_n) begin
					s1_reg <= 1'b0;
					s2_reg <= 1'b0;
					s3_reg <= 1'b0;
					filt_reg <= 1'b0;
				end else begin
					s1_reg <= async_in[g];
					s2_reg <= s1_reg;
					s3_reg <= s2_reg;
					filt_reg <= agree ? s3_reg : filt_reg;
				end
			end
			assign filt[g] = filt_reg;
			assign rise[g] = agree && s3_reg && !filt_reg;
		end
	endgenerate
	wire logic main_rise = rise[0];
	wire logic sec_rise = rise[1];
	wire logic sec_running = filt[2];

	// ----------------------------------------------------------------
	// PLL: quarter-period ticks from the measured input period
	// ----------------------------------------------------------------
	// Limitation: input must stay below a quarter of i_clk for clean ticks
	logic [TW-1:0] per_cnt_reg;
	logic [TW-1:0] period_reg;
	logic [TW-1:0] sub_cnt_reg;
	logic [1:0] sub_idx_reg;
	wire logic [TW-1:0] quarter = period_reg >> 2;
	wire logic sub_hit = (sub_cnt_reg + TW'(1) >= quarter) && (sub_idx_reg != Q_LAST);
	wire logic pll_tick = main_rise || sub_hit;

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			per_cnt_reg <= TMR_ZERO;
			period_reg <= TMR_ZERO;
			sub_cnt_reg <= TMR_ZERO;
			sub_idx_reg <= Q_FIRST;
		end else if (main_rise) begin
			period_reg <= per_cnt_reg + TW'(1);
			per_cnt_reg <= TMR_ZERO;
			sub_cnt_reg <= TMR_ZERO;
			sub_idx_reg <= Q_FIRST;
		end else begin
			per_cnt_reg <= (&per_cnt_reg) ? per_cnt_reg : per_cnt_reg + TW'(1);
			sub_cnt_reg <= sub_hit ? TMR_ZERO : sub_cnt_reg + TW'(1);
			sub_idx_reg <= sub_hit ? sub_idx_reg + 2'h1 : sub_idx_reg;
		end
	end

	// ----------------------------------------------------------------
	// Oscillator control register and its write policy
	// ----------------------------------------------------------------
	logic scs_reg;
	logic scs_next;
	wire logic wr_en = i_psel && i_penable && i_pwrite;
	wire logic sel_osc = (i_paddr == scsw_pkg::OSC_CTRL_OFFSET);
	wire logic sel_stat = (i_paddr == scsw_pkg::CLK_STATUS_OFFSET);
	wire logic any_reset = i_ext_reset || i_wdt_reset || i_brownout_reset;
	wire logic switch_allowed = !i_clock_switch_enable_cfg && i_secondary_osc_enable;

	// Bit forced clear whenever switching is not allowed or a reset occurs
	always_comb begin
		scs_next = scs_reg;
		if (wr_en && sel_osc) begin
			scs_next = i_pwdata[0];
		end
		if (!switch_allowed || any_reset) begin
			scs_next = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Sequencer next-state logic
	// ----------------------------------------------------------------
	scsw_pkg::scsw_state_t state_reg;
	scsw_pkg::scsw_state_t state_next;
	logic [TW-1:0] tmr_reg;
	logic [TW-1:0] tmr_next;
	logic active_sec_reg;
	logic active_sec_next;
	logic tgt_sec_reg;
	logic tgt_sec_next;
	logic sleep_pend_reg;
	logic [1:0] q_reg;

	wire logic src_tick = active_sec_reg ? sec_rise : (pll_mode ? pll_tick : main_rise);
	wire logic run_tick = (state_reg == scsw_pkg::ST_RUN) && src_tick;
	// Stopping only as phase four completes leaves the core at first quarter
	wire logic q1_boundary = run_tick && (q_reg == Q_LAST);
	wire logic tgt_rise = tgt_sec_reg ? sec_rise : main_rise;
	wire logic wake = i_ext_reset || i_wdt_reset || i_wake_irq;
	wire logic want_sec = scs_reg && !active_sec_reg && sec_running;
	wire logic want_main = !scs_reg && active_sec_reg;

	always_comb begin
		state_next = state_reg;
		tmr_next = tmr_reg;
		active_sec_next = active_sec_reg;
		tgt_sec_next = tgt_sec_reg;
		unique case (state_reg)
			scsw_pkg::ST_POWERUP_DELAY_TIMER: begin
				tmr_next = tmr_reg + TW'(1);
				if (!i_powerup_delay_enable || tmr_reg == POWERUP_DELAY_TIMER_LAST) begin
					tmr_next = TMR_ZERO;
					state_next = crystal_mode ? scsw_pkg::ST_OST : scsw_pkg::ST_RUN;
				end
			end
			scsw_pkg::ST_OST: begin
				if (main_rise) begin
					tmr_next = tmr_reg + TW'(1);
					if (tmr_reg == OST_LAST) begin
						tmr_next = TMR_ZERO;
						state_next = pll_mode ? scsw_pkg::ST_PLL : scsw_pkg::ST_RUN;
					end
				end
			end
			scsw_pkg::ST_PLL: begin
				tmr_next = tmr_reg + TW'(1);
				if (tmr_reg == PLL_LAST) begin
					tmr_next = TMR_ZERO;
					state_next = scsw_pkg::ST_RUN;
				end
			end
			scsw_pkg::ST_RUN: begin
				tmr_next = TMR_ZERO;
				if (active_sec_reg && (i_ext_reset || i_wdt_reset)) begin
					tgt_sec_next = 1'b0;
					state_next = scsw_pkg::ST_SYNC;
				end else if (q1_boundary && sleep_pend_reg) begin
					state_next = scsw_pkg::ST_SLEEP;
				end else if (q1_boundary && want_sec) begin
					tgt_sec_next = 1'b1;
					state_next = scsw_pkg::ST_SYNC;
				end else if (q1_boundary && want_main) begin
					tgt_sec_next = 1'b0;
					state_next = crystal_mode ? scsw_pkg::ST_SW_OST : scsw_pkg::ST_SYNC;
				end
			end
			scsw_pkg::ST_SYNC: begin
				if (tgt_rise) begin
					tmr_next = tmr_reg + TW'(1);
					if (tmr_reg == SYNC_LAST) begin
						tmr_next = TMR_ZERO;
						active_sec_next = tgt_sec_reg;
						state_next = scsw_pkg::ST_RUN;
					end
				end
			end
			scsw_pkg::ST_SW_OST: begin
				if (main_rise) begin
					tmr_next = tmr_reg + TW'(1);
					if (tmr_reg == OST_LAST) begin
						tmr_next = TMR_ZERO;
						state_next = pll_mode ? scsw_pkg::ST_SW_PLL : scsw_pkg::ST_SYNC;
					end
				end
			end
			scsw_pkg::ST_SW_PLL: begin
				tmr_next = tmr_reg + TW'(1);
				if (tmr_reg == PLL_LAST) begin
					tmr_next = TMR_ZERO;
					state_next = scsw_pkg::ST_SYNC;
				end
			end
			scsw_pkg::ST_SLEEP: begin
				tmr_next = TMR_ZERO;
				if (wake) begin
					// A reset wake returns to main; an interrupt keeps the source
					tgt_sec_next = active_sec_reg && !(i_ext_reset || i_wdt_reset);
					active_sec_next = 1'b0;
					state_next = (crystal_mode && !tgt_sec_next) ?
						scsw_pkg::ST_SW_OST : scsw_pkg::ST_SYNC;
				end
			end
		endcase
		// Brown-out restarts the power-up timer from any state, back on main
		if (i_brownout_reset) begin
			state_next = scsw_pkg::ST_POWERUP_DELAY_TIMER;
			tmr_next = TMR_ZERO;
			active_sec_next = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Sequencer and control state
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			state_reg <= scsw_pkg::ST_POWERUP_DELAY_TIMER;
			tmr_reg <= TMR_ZERO;
			active_sec_reg <= 1'b0;
			tgt_sec_reg <= 1'b0;
			scs_reg <= scsw_pkg::OSC_CTRL_RESET;
		end else begin
			state_reg <= state_next;
			tmr_reg <= tmr_next;
			active_sec_reg <= active_sec_next;
			tgt_sec_reg <= tgt_sec_next;
			scs_reg <= scs_next;
		end
	end

	// Sleep request waits for the next first-quarter boundary
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			sleep_pend_reg <= 1'b0;
		end else if (i_sleep_req) begin
			sleep_pend_reg <= 1'b1;
		end else if (state_reg == scsw_pkg::ST_SLEEP) begin
			sleep_pend_reg <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Quarter phases, tick output and divide-by-four pin
	// ----------------------------------------------------------------
	logic tick_reg;
	logic [1:0] div4_reg;
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			q_reg <= Q_FIRST;
			tick_reg <= 1'b0;
			div4_reg <= 2'h0;
		end else begin
			q_reg <= run_tick ? q_reg + 2'h1 : q_reg;
			tick_reg <= run_tick;
			div4_reg <= main_rise ? div4_reg + 2'h1 : div4_reg;
		end
	end
	wire logic sleeping = (state_reg == scsw_pkg::ST_SLEEP);
	// Pin behaviour by mode; low in sleep so the pin never floats mid-cycle
	assign o_osc_output_pin_o = div4_mode && !sleeping && div4_reg[1];
	assign o_osc_output_pin_oe = div4_mode;
	assign o_port_a_bit6_gpio = gpio_mode;
	assign o_osc_feedback_enable = crystal_mode && !sleeping;
	assign o_main_osc_enable = !sleeping;
	assign o_sys_clk_tick = tick_reg;
	assign o_q_phase = q_reg;
	assign o_pll_enable = pll_mode;
	assign o_sys_clock_is_secondary = active_sec_reg;
	assign o_hold_in_reset = (state_reg == scsw_pkg::ST_POWERUP_DELAY_TIMER) ||
		(state_reg == scsw_pkg::ST_OST) || (state_reg == scsw_pkg::ST_PLL);
	assign o_core_frozen = (state_reg != scsw_pkg::ST_RUN);

	// ----------------------------------------------------------------
	// APB read path, zero wait states
	// ----------------------------------------------------------------
	logic [31:0] rdata_reg;
	logic [31:0] stat_word;
	always_comb begin
		stat_word = 32'h0000_0000;
		stat_word[scsw_pkg::STAT_ACTIVE_SEC_BIT] = active_sec_reg;
		stat_word[scsw_pkg::STAT_PLL_EN_BIT] = pll_mode;
		stat_word[scsw_pkg::STAT_STATE_LSB +: 3] = state_reg;
		stat_word[scsw_pkg::STAT_HOLD_BIT] = o_hold_in_reset;
		stat_word[scsw_pkg::STAT_SEC_RUN_BIT] = sec_running;
	end

	// Captured in the setup phase so the access phase answers at once
	wire logic [31:0] rd_mux = sel_osc ? {31'h0000_0000, scs_reg} :
		(sel_stat ? stat_word : 32'h0000_0000);

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			rdata_reg <= 32'h0000_0000;
		end else if (i_psel && !i_penable) begin
			rdata_reg <= rd_mux;
		end
	end

	assign o_prdata = rdata_reg;
	assign o_pready = 1'b1;
	assign o_pslverr = i_psel && i_penable && !sel_osc && !(sel_stat && !i_pwrite);

endmodule : scsw_clock_ctrl

//--- rtl/scsw_pkg.sv
// Constants, register map and state codes of the system clock switch block.
// Assumes a 25 MHz system clock and a 32-bit APB register port.
package scsw_pkg;

	// ----------------------------------------------------------------
	// Clock rate and documented delays
	// ----------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 40;
	localparam int unsigned POWERUP_DELAY_TIMER_TIME_MS = 72;
	localparam int unsigned PLL_LOCK_TIME_MS = 2;
	localparam int unsigned NS_PER_MS = 1000000;
	// Least times, so round up to whole cycles
	localparam int unsigned POWERUP_DELAY_TIMER_CYCLES =
		(POWERUP_DELAY_TIMER_TIME_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned PLL_LOCK_CYCLES =
		(PLL_LOCK_TIME_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned OST_EDGES = 1024;
	localparam int unsigned SYNC_EDGES = 8;
	localparam int unsigned PLL_MULT = 4;
	localparam int unsigned TMR_W = 21;

	// ----------------------------------------------------------------
	// Main oscillator mode encodings
	// ----------------------------------------------------------------
	localparam logic [2:0] MODE_LOW_POWER_CRYSTAL = 3'h0;
	localparam logic [2:0] MODE_CRYSTAL_RESONATOR = 3'h1;
	localparam logic [2:0] MODE_HIGH_SPEED_CRYSTAL = 3'h2;
	localparam logic [2:0] MODE_RESISTOR_CAP_OSC = 3'h3;
	localparam logic [2:0] MODE_EXTERNAL_CLOCK_IN = 3'h4;
	localparam logic [2:0] MODE_EXTERNAL_CLOCK_IN_GPIO = 3'h5;
	localparam logic [2:0] MODE_HIGH_SPEED_PLL = 3'h6;
	localparam logic [2:0] MODE_RESISTOR_CAP_OSC_GPIO = 3'h7;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [11:0] OSC_CTRL_OFFSET = 12'h000;
	localparam logic [11:0] CLK_STATUS_OFFSET = 12'h004;
	localparam logic OSC_CTRL_RESET = 1'b0;
	localparam int unsigned STAT_ACTIVE_SEC_BIT = 0;
	localparam int unsigned STAT_PLL_EN_BIT = 1;
	localparam int unsigned STAT_STATE_LSB = 2;
	localparam int unsigned STAT_HOLD_BIT = 5;
	localparam int unsigned STAT_SEC_RUN_BIT = 6;

	// ----------------------------------------------------------------
	// Sequencer states, Gray along the PLL power-up path and the switch to secondary
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_POWERUP_DELAY_TIMER = 3'h0,
		ST_OST = 3'h1,
		ST_PLL = 3'h3,
		ST_RUN = 3'h2,
		ST_SYNC = 3'h6,
		ST_SW_OST = 3'h7,
		ST_SW_PLL = 3'h5,
		ST_SLEEP = 3'h4
	} scsw_state_t;

endpackage : scsw_pkg

//--- bench/scsw_props.sv
// Concurrent checks on the clock switch block, bound to its top ports.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
module scsw_props #(
	parameter int unsigned P_POWERUP_DELAY_TIMER_CYCLES = 20
) (
	input logic i_clk,
	input logic i_rst_n,
	input logic i_psel,
	input logic i_penable,
	input logic i_pwrite,
	input logic [11:0] i_paddr,
	input logic [31:0] o_prdata,
	input logic [2:0] i_osc_mode_cfg,
	input logic i_clock_switch_enable_cfg,
	input logic i_powerup_delay_enable,
	input logic i_secondary_osc_enable,
	input logic i_brownout_reset,
	input logic i_sleep_req,
	input logic i_wake_irq,
	input logic [1:0] o_q_phase,
	input logic o_hold_in_reset,
	input logic o_core_frozen,
	input logic o_pll_enable,
	input logic o_main_osc_enable,
	input logic o_osc_feedback_enable,
	input logic o_osc_output_pin_o,
	input logic o_osc_output_pin_oe,
	input logic o_port_a_bit6_gpio,
	input logic o_sys_clock_is_secondary
);
	logic [31:0] hold_cnt_reg;
	logic por_flag_reg;

	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	// Hold length, restarted by power-on or brown-out
	always_ff @(posedge i_clk) begin
		if (!i_rst_n || i_brownout_reset || !o_hold_in_reset) begin
			hold_cnt_reg <= 32'h0;
		end else begin
			hold_cnt_reg <= hold_cnt_reg + 32'h1;
		end
	end

	// Marks holds that owe the full power-up delay; other resets may hold briefly
	always_ff @(posedge i_clk) begin
		if (!i_rst_n || i_brownout_reset) begin
			por_flag_reg <= 1'b1;
		end else if (!o_hold_in_reset) begin
			por_flag_reg <= 1'b0;
		end
	end

	// ----
	// Sleep entry and exit steps
	// ----
	sequence s_sleep_cmd;
		i_sleep_req && !o_core_frozen;
	endsequence
	sequence s_wake_cmd;
		!o_main_osc_enable ##1 (i_wake_irq && !o_main_osc_enable);
	endsequence

	a_pll_mode_only:
		assert property (o_pll_enable == (i_osc_mode_cfg == scsw_pkg::MODE_HIGH_SPEED_PLL))
		else $error("pll enable outside pll mode");
	a_upper_bits_zero:
		assert property (i_psel && i_penable && !i_pwrite && i_paddr == 12'h000
			|-> o_prdata[31:1] == 31'h0)
		else $error("control upper bits not zero");
	a_switch_allowed:
		assert property ($rose(o_sys_clock_is_secondary)
			|-> !i_clock_switch_enable_cfg && i_secondary_osc_enable)
		else $error("switched while not allowed");
	a_powerup_hold:
		assert property ($rose(i_rst_n) |-> o_hold_in_reset && o_core_frozen)
		else $error("no hold after reset");
	a_powerup_delay_timer_length:
		assert property ($fell(o_hold_in_reset) && por_flag_reg && i_powerup_delay_enable
			|-> hold_cnt_reg >= P_POWERUP_DELAY_TIMER_CYCLES)
		else $error("power-up hold too short");
	a_sleep_entry:
		assert property (s_sleep_cmd |-> ##[1:160] !o_main_osc_enable)
		else $error("sleep not entered");
	a_sleep_state:
		assert property (!o_main_osc_enable
			|-> o_core_frozen && !o_osc_feedback_enable && o_q_phase == 2'h0)
		else $error("sleep state wrong");
	a_sleep_pin_low:
		assert property (!o_main_osc_enable && i_osc_mode_cfg inside {3'h3, 3'h4}
			|-> o_osc_output_pin_oe && !o_osc_output_pin_o)
		else $error("output pin not low in sleep");
	a_gpio_modes:
		assert property (o_port_a_bit6_gpio == (i_osc_mode_cfg inside {3'h5, 3'h7}))
		else $error("gpio select wrong");
	a_div4_enable:
		assert property (i_osc_mode_cfg inside {3'h3, 3'h4} && o_main_osc_enable
			|-> o_osc_output_pin_oe)
		else $error("divided clock not driven");
	a_wake_irq:
		assert property (s_wake_cmd |-> ##[1:16] o_main_osc_enable)
		else $error("no wake on interrupt");
endmodule : scsw_props

bind scsw_clock_ctrl scsw_props #(.P_POWERUP_DELAY_TIMER_CYCLES(P_POWERUP_DELAY_TIMER_CYCLES)) u_scsw_props (
	.i_clk(i_clk),
	.i_rst_n(i_rst_n),
	.i_psel(i_psel),
	.i_penable(i_penable),
	.i_pwrite(i_pwrite),
	.i_paddr(i_paddr),
	.o_prdata(o_prdata),
	.i_osc_mode_cfg(i_osc_mode_cfg),
	.i_clock_switch_enable_cfg(i_clock_switch_enable_cfg),
	.i_powerup_delay_enable(i_powerup_delay_enable),
	.i_secondary_osc_enable(i_secondary_osc_enable),
	.i_brownout_reset(i_brownout_reset),
	.i_sleep_req(i_sleep_req),
	.i_wake_irq(i_wake_irq),
	.o_q_phase(o_q_phase),
	.o_hold_in_reset(o_hold_in_reset),
	.o_core_frozen(o_core_frozen),
	.o_pll_enable(o_pll_enable),
	.o_main_osc_enable(o_main_osc_enable),
	.o_osc_feedback_enable(o_osc_feedback_enable),
	.o_osc_output_pin_o(o_osc_output_pin_o),
	.o_osc_output_pin_oe(o_osc_output_pin_oe),
	.o_port_a_bit6_gpio(o_port_a_bit6_gpio),
	.o_sys_clock_is_secondary(o_sys_clock_is_secondary)
);

//--- bench/scsw_osc_model.sv
// Oscillator sources at the block's pins: main and secondary.
// Assumes half periods far longer than the 40 ns system clock.
`timescale 1ns/1ps
module scsw_osc_model #(
	parameter int MAIN_HALF_NS = 330,
	parameter int SEC_HALF_NS = 1160
) (
	input wire logic i_main_run,
	input wire logic i_sec_on,
	output logic o_main_pin,
	output logic o_sec_pin,
	output logic o_sec_running
);
	// Main source stops when the device turns it off; pull-up sets the idle level
	initial begin
		o_main_pin = 1'b0;
		forever begin
			#(MAIN_HALF_NS);
			if (i_main_run) begin
				o_main_pin = ~o_main_pin;
			end else begin
				o_main_pin = 1'b1;
			end
		end
	end

	// Secondary crystal only swings while its enable is set
	initial begin
		o_sec_pin = 1'b0;
		forever begin
			#(SEC_HALF_NS);
			o_sec_pin = i_sec_on ? ~o_sec_pin : 1'b0;
		end
	end

	assign o_sec_running = i_sec_on;
endmodule : scsw_osc_model

//--- bench/testbench.sv
// Self-checking bench: APB access, source switching, sleep and power-up.
// Assumes shortened power-up and lock counts; oscillators come from the model.
`timescale 1ns/1ps
module testbench;
	logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [2:0] mode = 3'h3;
	logic sw_cfg = 1'b1, sec_en = 1'b0, bor = 1'b0, ext_rst = 1'b0;
	logic wake = 1'b0, sleep = 1'b0, m_d = 1'b0, s_d = 1'b0, e;
	logic pready, pslverr, main_pin, sec_pin, sec_run, tick, hold, frozen, pll;
	logic main_on, fb, pin_o, pin_oe, gpio, on_sec;
	logic [1:0] qph;
	int err_total = 0, tests_run = 0, cyc = 0, main_cnt = 0, sec_cnt = 0, tick_cnt = 0, n;

	always #20 clk = ~clk;

	scsw_clock_ctrl #(.P_POWERUP_DELAY_TIMER_CYCLES(20), .P_PLL_LOCK_CYCLES(10)) i_scsw_clock_ctrl (
		.i_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .i_osc_mode_cfg(mode),
		.i_clock_switch_enable_cfg(sw_cfg), .i_powerup_delay_enable(1'b1),
		.i_secondary_osc_enable(sec_en), .i_brownout_reset(bor), .i_ext_reset(ext_rst),
		.i_wdt_reset(1'b0), .i_wake_irq(wake), .i_sleep_req(sleep),
		.i_osc_input_pin(main_pin), .i_secondary_osc_pin(sec_pin),
		.i_secondary_osc_running(sec_run), .o_sys_clk_tick(tick), .o_q_phase(qph),
		.o_hold_in_reset(hold), .o_core_frozen(frozen), .o_pll_enable(pll),
		.o_main_osc_enable(main_on), .o_osc_feedback_enable(fb),
		.o_osc_output_pin_o(pin_o), .o_osc_output_pin_oe(pin_oe),
		.o_port_a_bit6_gpio(gpio), .o_sys_clock_is_secondary(on_sec));

	scsw_osc_model i_scsw_osc_model (.i_main_run(main_on), .i_sec_on(sec_en),
		.o_main_pin(main_pin), .o_sec_pin(sec_pin), .o_sec_running(sec_run));

	// Edge, tick and cycle counters; the cycle ceiling cuts a hang short
	always @(posedge clk) begin
		m_d <= main_pin;
		s_d <= sec_pin;
		main_cnt += int'(main_pin && !m_d);
		sec_cnt += int'(sec_pin && !s_d);
		tick_cnt += int'(tick === 1'b1);
		cyc++;
		if (cyc == 90000) begin
			err_total++;
			test_done();
		end
	end

	task automatic test_done();
		if (err_total == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : test_done

	task automatic chk(input logic ok, input string m);
		tests_run++;
		if (ok !== 1'b1) begin
			err_total++;
			$display("[ERR] %0t %s", $time, m);
		end
	endtask : chk

	// One APB transfer; request held until pready is seen
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rd = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Waits for the source flag, then checks edges of the new source
	task automatic fin(input logic v, input int t, input int lo, input int hi);
		int k;
		while (on_sec !== v) @(posedge clk);
		k = (v ? sec_cnt : main_cnt) - t;
		@(posedge clk);
		chk(k >= lo && k <= hi && frozen === 1'b0, "switch edge count");
	endtask : fin

	task automatic go(input logic v, input int lo, input int hi);
		int t;
		t = v ? sec_cnt : main_cnt;
		apb(1'b1, 12'h000, {31'h7FFFFFFF, v});
		apb(1'b0, 12'h000, 32'h0);
		chk(rd === {31'h0, v}, "select readback");
		fin(v, t, lo, hi);
	endtask : go

	// Ticks over p main periods, started on a main edge
	task automatic ticks(input int p, output int k);
		int t;
		t = main_cnt;
		while (main_cnt == t) @(posedge clk);
		k = tick_cnt;
		t = main_cnt;
		while (main_cnt < t + p) @(posedge clk);
		k = tick_cnt - k;
	endtask : ticks

	// ----
	// Main sequence
	// ----
	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		n = 0;
		@(posedge clk);
		while (hold !== 1'b0) begin
			@(posedge clk);
			n++;
		end
		chk(n >= 20 && n < 60, "power-up hold");
		apb(1'b0, 12'h000, 32'h0);
		chk(rd === 32'h0 && e === 1'b0, "select after reset");
		apb(1'b1, 12'h000, 32'h1);
		apb(1'b0, 12'h000, 32'h0);
		chk(rd === 32'h0, "switch disabled");
		sw_cfg <= 1'b0;
		apb(1'b1, 12'h000, 32'h1);
		apb(1'b0, 12'h000, 32'h0);
		chk(rd === 32'h0 && on_sec === 1'b0, "secondary off");
		apb(1'b0, 12'h008, 32'h0);
		chk(e === 1'b1 && rd === 32'h0, "unmapped read");
		apb(1'b1, 12'h004, 32'h1);
		chk(e === 1'b1, "status write");
		ticks(8, n);
		chk(n >= 7 && n <= 9 && pll === 1'b0, "no multiply");
		sec_en <= 1'b1;
		repeat (8) @(posedge clk);
		go(1'b1, 8, 12);
		n = main_cnt;
		// Edges seen here reach the design's counter a few cycles later
		repeat (2) @(posedge clk);
		ext_rst <= 1'b1;
		@(posedge clk);
		ext_rst <= 1'b0;
		apb(1'b0, 12'h000, 32'h0);
		chk(rd === 32'h0, "ext reset select");
		fin(1'b0, n, 8, 32);
		go(1'b1, 8, 12);
		mode <= 3'h1;
		go(1'b0, 1032, 1064);
		go(1'b1, 8, 12);
		mode <= 3'h6;
		go(1'b0, 1032, 1064);
		ticks(2, n);
		ticks(8, n);
		chk(n >= 31 && n <= 33 && pll === 1'b1, "pll ratio");
		mode <= 3'h3;
		repeat (40) @(posedge clk);
		sleep <= 1'b1;
		@(posedge clk);
		sleep <= 1'b0;
		while (main_on !== 1'b0) @(posedge clk);
		@(posedge clk);
		chk(pin_oe === 1'b1 && pin_o === 1'b0 && fb === 1'b0, "sleep pins");
		chk(qph === 2'h0 && frozen === 1'b1, "sleep phase");
		wake <= 1'b1;
		while (main_on !== 1'b1) @(posedge clk);
		wake <= 1'b0;
		while (frozen !== 1'b0) @(posedge clk);
		chk(on_sec === 1'b0, "wake source");
		mode <= 3'h7;
		repeat (2) @(posedge clk);
		chk(gpio === 1'b1 && pin_oe === 1'b0, "gpio mode");
		bor <= 1'b1;
		repeat (4) @(posedge clk);
		chk(hold === 1'b1, "brown-out hold");
		bor <= 1'b0;
		n = 0;
		while (hold !== 1'b0) begin
			@(posedge clk);
			n++;
		end
		chk(n >= 20 && n < 60, "brown-out delay");
		mode <= 3'h1;
		bor <= 1'b1;
		@(posedge clk);
		bor <= 1'b0;
		n = main_cnt;
		@(posedge clk);
		while (hold !== 1'b0) @(posedge clk);
		chk(main_cnt - n >= 1024 && main_cnt - n <= 1030, "crystal start-up hold");
		test_done();
	end
endmodule : testbench
